// ===== rtl/ea_cfg.svh
// encodings, word counts and extension-word step for effective-address decode
`ifndef EA_CFG_SVH
`define EA_CFG_SVH

// ---------------------------------------------------------------
// mode and register field codes
// ---------------------------------------------------------------
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_AIND 3'h2
`define MODE_APOST 3'h3
`define MODE_APRE 3'h4
`define MODE_ADISP 3'h5
`define MODE_AIDX 3'h6
`define MODE_EXT 3'h7
`define REG_ABS_W 3'h0
`define REG_ABS_L 3'h1
`define REG_PC_D16 3'h2
`define REG_PC_IDX 3'h3
`define REG_IMM 3'h4

// ---------------------------------------------------------------
// displacement size codes
// ---------------------------------------------------------------
`define DSZ_NULL 2'h0
`define DSZ_WORD 2'h1
`define DSZ_LONG 2'h2

// ---------------------------------------------------------------
// extension word counts
// ---------------------------------------------------------------
`define WORDS_ABS_W 3'h1
`define WORDS_ABS_L 3'h2
`define WORDS_BYTE 3'h1
`define WORDS_WORD 3'h1
`define WORDS_LONG 3'h2
`define WORDS_SINGLE 3'h2
`define WORDS_DOUBLE 3'h4
`define WORDS_EXTENDED 3'h6
`define WORDS_PACKED 3'h6
`define WORDS_FULL_EXT 3'h1

// byte distance from instruction word to its first extension word
`define EXT_STEP 32'h00000002

`endif

// ===== rtl/ea_class_if.sv
// carrier between the decoder and its category classifier
`timescale 1ns/100ps
`default_nettype none

interface ea_class_if;
  logic [2:0] mode;
  logic [2:0] regf;
  ea_pkg::cat_s cats;
  logic legal;

  modport req (output mode, output regf, input cats, input legal);
  modport cls (input mode, input regf, output cats, output legal);
endinterface : ea_class_if

`default_nettype wire

// ===== rtl/ea_classify.sv
// mode/register field to addressing category classifier
`timescale 1ns/100ps
`default_nettype none
`include "ea_cfg.svh"

module ea_classify (
  ea_class_if.cls bus // mode/register in, categories out
);
  import ea_pkg::*;

  // -------------------------------------------------------------
  // field decode
  // -------------------------------------------------------------
  wire logic is_ext = (bus.mode == `MODE_EXT);
  wire logic is_areg = (bus.mode == `MODE_AREG);
  wire logic is_dreg = (bus.mode == `MODE_DREG);
  wire logic ext_legal = (bus.regf <= `REG_IMM);
  wire logic is_imm = is_ext && (bus.regf == `REG_IMM);
  wire logic ctl_reg = (bus.mode == `MODE_AIND) || (bus.mode == `MODE_ADISP) ||
                       (bus.mode == `MODE_AIDX);
  wire logic ctl_ext = is_ext && (bus.regf <= `REG_PC_IDX);

  // -------------------------------------------------------------
  // categories
  // -------------------------------------------------------------
  assign bus.legal = !is_ext || ext_legal;
  assign bus.cats.data = bus.legal && !is_areg;
  assign bus.cats.memory = bus.legal && !is_areg && !is_dreg;
  assign bus.cats.control = ctl_reg || (ctl_ext && !is_imm);
  // every 111 form, absolute, pc-relative or immediate, is classed read-only
  assign bus.cats.alterable = !is_ext;
  assign bus.cats.alt_mem = bus.cats.alterable && bus.cats.memory;
  assign bus.cats.data_alt = bus.cats.alterable && bus.cats.data;

endmodule : ea_classify

`default_nettype wire

// ===== rtl/ea_mode_decode_classify.sv
// effective-address decode: pc memory indirect preindexed, absolute, immediate
// What this block does
// - pc preindexed: pointer at pc+bd+index, fetched long plus outer disp.
// - the pc value used is the address of the first extension word.
// - pc memory indirect operands are program reads, never write targets.
// - omitted or suppressed base, index, bd or od count as zero.
// - bd and od each null, word or long, fetching matching word counts.
// - suppressed pc base drops pc but access stays program space.
// - absolute short: one word, sign-extended to a 32-bit address.
// - absolute long (reg 001): two words, high half first.
// - immediate byte from low byte, word whole, long two words high first.
// - float immediates: single two, double four, extended and packed six words.
// - classify data, memory, alterable, control; check operand against allowed set.
// - alterable-memory and data-alterable are ANDs of base categories.
// - mode 110 forms are data, memory, control and alterable.
// - pc displacement and indexed forms are data, memory, control, not alterable.
// - immediates are data and memory, not control or alterable.
// - displacements and index sign-extend to 32 bits before the add.
`timescale 1ns/100ps
`default_nettype none
`include "ea_cfg.svh"

module ea_mode_decode_classify (
  input wire logic mclk, // core clock
  input wire logic reset, // synchronous reset, high
  input wire logic start, // one-cycle request, taken in idle
  input wire logic [2:0] ea_mode, // mode field
  input wire logic [2:0] ea_reg, // register field
  input wire logic mem_ind, // 111/011 uses memory indirect preindexed form
  input wire logic [31:0] instr_addr, // address of the instruction word
  input wire logic base_suppress, // pc base suppressed (zero pc)
  input wire logic index_suppress, // index suppressed
  input wire logic [1:0] bd_size, // base displacement size code
  input wire logic [1:0] od_size, // outer displacement size code
  input wire logic [31:0] index_val, // index register contents
  input wire logic index_long, // index taken as long word
  input wire logic [1:0] index_scale, // index shift 0..3
  input wire ea_pkg::imm_size_e imm_size, // immediate operand length
  input wire ea_pkg::cat_s need_cats, // categories the instruction demands
  input wire logic write_dest, // operand is a destination
  input wire logic ext_valid, // extension word present
  input wire logic [15:0] ext_word, // extension word
  output logic ext_ready, // extension word taken this cycle
  output logic mem_req, // long-word read request
  output logic [31:0] mem_addr, // read address
  output logic mem_prog, // read is a program-space access
  input wire logic mem_ack, // read data valid
  input wire logic [31:0] mem_rdata, // read data
  output logic busy, // request in progress
  output logic done, // one-cycle result strobe
  output logic [31:0] ea_addr, // effective address
  output logic [95:0] imm_data, // immediate operand, first word highest
  output logic [2:0] ext_count, // extension words consumed
  output logic ea_formed, // ea_addr holds a computed address
  output logic prog_space, // operand lives in program space
  output ea_pkg::cat_s cats, // categories of the mode
  output logic cat_fault, // demanded category missing
  output logic write_fault // destination not alterable
);
  import ea_pkg::*;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [2:0] disp_words(input logic [1:0] sz);
    case (sz)
      `DSZ_WORD: disp_words = 3'h1;
      `DSZ_LONG: disp_words = 3'h2;
      default: disp_words = 3'h0;
    endcase
  endfunction : disp_words

  function automatic logic [31:0] disp_ext(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      `DSZ_WORD: disp_ext = {{16{v[15]}}, v[15:0]};
      `DSZ_LONG: disp_ext = v;
      default: disp_ext = 32'h00000000;
    endcase
  endfunction : disp_ext

  function automatic logic [2:0] imm_words(input imm_size_e sz);
    case (sz)
      IMM_BYTE: imm_words = `WORDS_BYTE;
      IMM_WORD: imm_words = `WORDS_WORD;
      IMM_LONG: imm_words = `WORDS_LONG;
      IMM_SINGLE: imm_words = `WORDS_SINGLE;
      IMM_DOUBLE: imm_words = `WORDS_DOUBLE;
      IMM_EXTENDED: imm_words = `WORDS_EXTENDED;
      default: imm_words = `WORDS_PACKED;
    endcase
  endfunction : imm_words

  // -------------------------------------------------------------
  // classifier
  // -------------------------------------------------------------
  ea_class_if cif ();
  assign cif.mode = ea_mode;
  assign cif.regf = ea_reg;
  ea_classify u_cls (
    .bus(cif.cls)
  );

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  state_e state_q, state_d;
  logic [31:0] pc_q, idx_q, bd_q, od_q, ea_q, mem_addr_q;
  logic [95:0] imm_q;
  logic [2:0] wcnt_q, need_w_q, ext_count_q;
  logic [1:0] bdsz_q, odsz_q;
  logic bs_q, pcmi_q, absw_q, absl_q, imm_sel_q, formed_q, write_q;
  imm_size_e imsz_q;
  cat_s cats_q, need_q;

  // -------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------
  wire logic take = start && (state_q == S_IDLE);
  wire logic f_ext = (ea_mode == `MODE_EXT);
  wire logic f_absw = f_ext && (ea_reg == `REG_ABS_W);
  wire logic f_absl = f_ext && (ea_reg == `REG_ABS_L);
  wire logic f_imm = f_ext && (ea_reg == `REG_IMM);
  wire logic f_pcmi = f_ext && (ea_reg == `REG_PC_IDX) && mem_ind;
  wire logic [2:0] f_need = f_absw ? `WORDS_ABS_W :
                            f_absl ? `WORDS_ABS_L : imm_words(imm_size);
  wire logic [31:0] ix_ext = index_long ? index_val : {{16{index_val[15]}}, index_val[15:0]};
  wire logic [31:0] ix_scaled = index_suppress ? 32'h00000000 : (ix_ext << index_scale);

  // -------------------------------------------------------------
  // extension word stream and address arithmetic
  // -------------------------------------------------------------
  wire logic in_words = (state_q == S_FULL) || (state_q == S_BD) ||
                        (state_q == S_OD) || (state_q == S_GATHER);
  wire logic ext_take = ext_valid && in_words;
  wire logic [2:0] wcnt_inc = wcnt_q + 3'h1;
  wire logic [2:0] bd_w = disp_words(bdsz_q);
  wire logic [2:0] od_w = disp_words(odsz_q);
  wire logic [31:0] bd_shift = {bd_q[15:0], ext_word};
  wire logic [31:0] bd_now = ((state_q == S_BD) && ext_take) ? bd_shift : bd_q;
  wire logic [31:0] base_val = bs_q ? 32'h00000000 : pc_q;
  wire logic [31:0] iaddr = base_val + disp_ext(bd_now, bdsz_q) + idx_q;
  wire logic [31:0] od_ext = disp_ext(od_q, odsz_q);
  wire logic [95:0] imm_shift = {imm_q[79:0], ext_word};
  wire logic last_w = ext_take && (wcnt_inc == need_w_q);
  wire logic bd_last = ext_take && (state_q == S_BD) && (wcnt_inc == bd_w);
  wire logic od_last = ext_take && (state_q == S_OD) && (wcnt_inc == od_w);
  wire logic [31:0] abs_w = {{16{ext_word[15]}}, ext_word};
  wire logic [31:0] abs_l = {imm_q[15:0], ext_word};
  wire logic [95:0] imm_fin = (imsz_q == IMM_BYTE) ? {88'h0, ext_word[7:0]} : imm_shift;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (take) begin
          if (f_pcmi) begin
            state_d = S_FULL;
          end else if (f_absw || f_absl || f_imm) begin
            state_d = S_GATHER;
          end else begin
            state_d = S_DONE;
          end
        end
      end
      S_FULL: begin
        if (ext_take) begin
          state_d = (bd_w != 3'h0) ? S_BD : (od_w != 3'h0) ? S_OD : S_MEM;
        end
      end
      S_BD: begin
        if (bd_last) begin
          state_d = (od_w != 3'h0) ? S_OD : S_MEM;
        end
      end
      S_OD: begin
        if (od_last) begin
          state_d = S_MEM;
        end
      end
      S_MEM: begin
        if (mem_ack) begin
          state_d = S_DONE;
        end
      end
      S_GATHER: begin
        if (last_w) begin
          state_d = S_DONE;
        end
      end
      S_DONE: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  wire logic to_mem = (state_d == S_MEM) && (state_q != S_MEM);

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_q <= 32'h00000000;
      idx_q <= 32'h00000000;
      bdsz_q <= `DSZ_NULL;
      odsz_q <= `DSZ_NULL;
      bs_q <= 1'b0;
      pcmi_q <= 1'b0;
      absw_q <= 1'b0;
      absl_q <= 1'b0;
      imm_sel_q <= 1'b0;
      imsz_q <= IMM_BYTE;
      need_w_q <= 3'h0;
      cats_q <= '0;
      need_q <= '0;
      write_q <= 1'b0;
    end else if (take) begin
      pc_q <= instr_addr + `EXT_STEP;
      idx_q <= ix_scaled;
      bdsz_q <= bd_size;
      odsz_q <= od_size;
      bs_q <= base_suppress;
      pcmi_q <= f_pcmi;
      absw_q <= f_absw;
      absl_q <= f_absl;
      imm_sel_q <= f_imm;
      imsz_q <= imm_size;
      need_w_q <= f_need;
      cats_q <= cif.cats;
      need_q <= need_cats;
      write_q <= write_dest;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || take) begin
      wcnt_q <= 3'h0;
      bd_q <= 32'h00000000;
      od_q <= 32'h00000000;
      imm_q <= 96'h0;
      ext_count_q <= 3'h0;
    end else if (ext_take) begin
      wcnt_q <= (state_q == S_FULL || bd_last || od_last) ? 3'h0 : wcnt_inc;
      ext_count_q <= ext_count_q + 3'h1;
      if (state_q == S_BD) begin
        bd_q <= bd_shift;
      end
      if (state_q == S_OD) begin
        od_q <= {od_q[15:0], ext_word};
      end
      if (state_q == S_GATHER) begin
        imm_q <= last_w ? imm_fin : imm_shift;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || take) begin
      ea_q <= 32'h00000000;
      mem_addr_q <= 32'h00000000;
      formed_q <= 1'b0;
    end else begin
      if (to_mem) begin
        mem_addr_q <= iaddr;
      end
      if (state_q == S_MEM && mem_ack) begin
        ea_q <= mem_rdata + od_ext;
        formed_q <= 1'b1;
      end
      if (state_q == S_GATHER && last_w && (absw_q || absl_q)) begin
        ea_q <= absw_q ? abs_w : abs_l;
        formed_q <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign ext_ready = in_words;
  assign mem_req = (state_q == S_MEM);
  assign mem_addr = mem_addr_q;
  assign mem_prog = pcmi_q;
  assign busy = (state_q != S_IDLE);
  assign done = (state_q == S_DONE);
  assign ea_addr = ea_q;
  assign imm_data = imm_q;
  assign ext_count = ext_count_q;
  assign ea_formed = formed_q;
  assign prog_space = pcmi_q;
  assign cats = cats_q;
  assign cat_fault = |(need_q & ~cats_q);
  assign write_fault = write_q && !cats_q.alterable;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  wire logic [2:0] pcmi_words = `WORDS_FULL_EXT + bd_w + od_w;

  abs_short_a: assert property (@(posedge mclk) disable iff (reset)
    done && absw_q |-> ea_addr[31:16] == {16{ea_addr[15]}} && ext_count == 3'h1)
    else $error("absolute short address not sign-extended");
  abs_long_a: assert property (@(posedge mclk) disable iff (reset)
    (state_q == S_GATHER) && absl_q && last_w |=> ea_addr == {$past(imm_q[15:0]),
      $past(ext_word)} && ext_count == 3'h2)
    else $error("absolute long address misassembled");
  imm_double_a: assert property (@(posedge mclk) disable iff (reset)
    done && imm_sel_q && (imsz_q == IMM_DOUBLE) |-> ext_count == 3'h4)
    else $error("double immediate word count wrong");
  imm_byte_a: assert property (@(posedge mclk) disable iff (reset)
    done && imm_sel_q && (imsz_q == IMM_BYTE) |-> imm_data[95:8] == 88'h0
      && ext_count == 3'h1)
    else $error("byte immediate not from low byte");
  pc_base_a: assert property (@(posedge mclk) disable iff (reset)
    take |=> pc_q == $past(instr_addr) + `EXT_STEP)
    else $error("pc base is not first extension word address");
  outer_add_a: assert property (@(posedge mclk) disable iff (reset)
    mem_req && mem_ack |=> ea_addr == $past(mem_rdata) + $past(od_ext) ##1 !busy)
    else $error("outer displacement not added to pointer");
  pcmi_words_a: assert property (@(posedge mclk) disable iff (reset)
    done && pcmi_q |-> ext_count == pcmi_words)
    else $error("pc indirect extension word count wrong");
  pcmi_read_a: assert property (@(posedge mclk) disable iff (reset)
    done && pcmi_q |-> !cats.alterable && prog_space && (write_fault == write_q))
    else $error("pc memory indirect treated as writable");
  zero_pc_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(mem_req) && bs_q && (bdsz_q == `DSZ_NULL) |-> mem_addr == idx_q && mem_prog)
    else $error("suppressed pc still used or not program space");
  imm_class_a: assert property (@(posedge mclk) disable iff (reset)
    done && imm_sel_q |-> cats.data && cats.memory && !cats.control && !cats.alterable)
    else $error("immediate classified wrongly");
  combined_cat_a: assert property (@(posedge mclk) disable iff (reset)
    done |-> cats.alt_mem == (cats.alterable && cats.memory)
      && cats.data_alt == (cats.alterable && cats.data))
    else $error("combined categories inconsistent");

endmodule : ea_mode_decode_classify

`default_nettype wire

// ===== rtl/ea_pkg.sv
// types shared by the effective-address decode modules
package ea_pkg;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    IMM_BYTE = 3'h0,
    IMM_WORD = 3'h1,
    IMM_LONG = 3'h2,
    IMM_SINGLE = 3'h3,
    IMM_DOUBLE = 3'h4,
    IMM_EXTENDED = 3'h5,
    IMM_PACKED = 3'h6
  } imm_size_e;

  typedef struct packed {
    logic data_alt;
    logic alt_mem;
    logic alterable;
    logic control;
    logic memory;
    logic data;
  } cat_s;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_FULL = 7'h02,
    S_BD = 7'h04,
    S_OD = 7'h08,
    S_MEM = 7'h10,
    S_GATHER = 7'h20,
    S_DONE = 7'h40
  } state_e;

endpackage : ea_pkg

// ===== testbench/ea_partner_model.sv
// extension-word source and long-word memory for the ea decoder
`timescale 1ns/100ps
`default_nettype none

module ea_partner_model (
  input wire logic mclk, // core clock
  input wire logic reset, // sync reset, high
  input wire logic ext_ready, // word taken
  output logic ext_valid, // word offered
  output logic [15:0] ext_word, // offered word
  input wire logic mem_req, // read request
  input wire logic [31:0] mem_addr, // read address
  output logic mem_ack, // read answered
  output logic [31:0] mem_rdata // read data
);
  logic [15:0] words [8];
  logic [31:0] ptr_val;
  logic [31:0] addr_seen;
  logic slow = 1'b0;
  logic gap = 1'b0;
  logic tick = 1'b0;
  int n = 0;
  int rd = 0;
  int lat = 0;
  int wait_c = 0;

  task automatic load(input logic [15:0] w [8], input int cnt, input logic s, input int l,
                      input logic [31:0] pv);
    words = w;
    n = cnt;
    slow = s;
    lat = l;
    ptr_val = pv;
    rd = 0;
  endtask : load

  // slow mode offers a word only every other cycle
  always @(posedge mclk) begin
    tick <= ~tick;
    gap <= slow & ~gap;
    if (reset) rd <= 0;
    else if (ext_valid && ext_ready) rd <= rd + 1;
    wait_c <= mem_req ? wait_c + 1 : 0;
    if (mem_ack) addr_seen <= mem_addr;
  end

  // lines not in use carry a changing pattern; idle mem_rdata equals ptr_val every other cycle
  assign ext_valid = !reset && rd < n && !gap;
  assign ext_word = ext_valid ? words[rd] : {16{tick}} ^ 16'h3c5a;
  assign mem_ack = mem_req && wait_c >= lat;
  assign mem_rdata = mem_ack ? ptr_val : {32{tick}} ^ ~ptr_val;
endmodule : ea_partner_model

`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the effective-address decoder
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import ea_pkg::*;
  logic mclk, reset, start, mem_ind, base_suppress, index_suppress, index_long, write_dest;
  logic ext_valid, ext_ready, mem_req, mem_prog, mem_ack, busy, done, ea_formed, prog_space;
  logic cat_fault, write_fault;
  logic [2:0] ea_mode, ea_reg, ext_count;
  logic [1:0] bd_size, od_size, index_scale;
  logic [15:0] ext_word;
  logic [31:0] instr_addr, index_val, mem_addr, mem_rdata, ea_addr;
  logic [95:0] imm_data;
  imm_size_e imm_size;
  cat_s need_cats, cats;
  logic [15:0] wv [8] = '{16'h81a1, 16'h92b2, 16'ha3c3, 16'hb4d4, 16'hc5e5, 16'hd6f6,
                          16'he707, 16'hf818};
  int error_cnt = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  int lat;

  ea_mode_decode_classify ea_mode_decode_classify_i (.mclk, .reset, .start, .ea_mode, .ea_reg,
    .mem_ind, .instr_addr, .base_suppress, .index_suppress, .bd_size, .od_size, .index_val,
    .index_long, .index_scale, .imm_size, .need_cats, .write_dest, .ext_valid, .ext_word,
    .ext_ready, .mem_req, .mem_addr, .mem_prog, .mem_ack, .mem_rdata, .busy, .done, .ea_addr,
    .imm_data, .ext_count, .ea_formed, .prog_space, .cats, .cat_fault, .write_fault);
  ea_partner_model ea_partner_model_i (.mclk, .reset, .ext_ready, .ext_valid, .ext_word,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  // one request: start pulse, bounded wait for done, done lasts one cycle
  task automatic run();
    @(posedge mclk) #2;
    start = 1'b1;
    @(posedge mclk) #2;
    start = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 200) begin
      @(posedge mclk) #2;
      lat++;
    end
    chk(done, 1, "done seen");
    @(posedge mclk) #2;
    chk(done, 0, "done width");
  endtask : run

  function automatic cat_s exp_cats(input logic [2:0] m, input logic [2:0] r);
    cat_s c;
    c.data = m != 3'h1;
    c.memory = m > 3'h1;
    c.control = m inside {3'h2, 3'h5, 3'h6} || (m == 3'h7 && r <= 3'h3);
    c.alterable = m != 3'h7;
    if (m == 3'h7 && r > 3'h4) c = '0;
    c.alt_mem = c.alterable & c.memory;
    c.data_alt = c.alterable & c.data;
    return c;
  endfunction : exp_cats

  // ----
  // scenarios
  // ----
  task automatic t_classify();
    cat_s e;
    for (int m = 0; m < 8; m++) begin
      for (int r = 0; r < 8; r++) begin
        ea_mode = m[2:0];
        ea_reg = r[2:0];
        ea_partner_model_i.load(wv, 8, 1'b0, 0, 32'h0);
        run();
        e = exp_cats(m[2:0], r[2:0]);
        chk(cats, e, "cats");
        chk(cat_fault, e != 6'h3f, "cat fault");
        chk(write_fault, !e.alterable, "write fault");
        if (m != 7 || r > 4 || r == 2 || r == 3) chk(lat, 1, "latency");
        chk(ea_formed, m == 7 && r < 2, "formed");
      end
    end
    $display("test classify done");
  endtask : t_classify

  task automatic t_abs();
    logic [15:0] a [3] = '{16'h8000, 16'h7fff, 16'h1234};
    ea_mode = 3'h7;
    for (int i = 0; i < 3; i++) begin
      ea_reg = (i == 2) ? 3'h1 : 3'h0;
      ea_partner_model_i.load('{a[i], 16'h5678, 0, 0, 0, 0, 0, 0}, 2, i[0], 0, 32'h0);
      run();
      if (i == 0) chk(ea_addr, 32'hffff8000, "abs short");
      if (i == 1) chk(ea_addr, 32'h00007fff, "abs short");
      if (i == 2) chk(ea_addr, 32'h12345678, "abs long");
      chk(ext_count, (i == 2) ? 2 : 1, "abs count");
      chk(ea_formed, 1, "abs formed");
    end
    $display("test absolute done");
  endtask : t_abs

  task automatic t_imm();
    int cnt [7] = '{1, 1, 2, 2, 4, 6, 6};
    logic [95:0] e;
    ea_mode = 3'h7;
    ea_reg = 3'h4;
    for (int i = 0; i < 7; i++) begin
      imm_size = imm_size_e'(i[2:0]);
      ea_partner_model_i.load(wv, 8, i[0], 0, 32'h0);
      run();
      e = '0;
      for (int k = 0; k < cnt[i]; k++) e = {e[79:0], wv[k]};
      if (i == 0) e = {88'h0, wv[0][7:0]};
      chk(imm_data, e, "imm data");
      chk(ext_count, cnt[i], "imm count");
    end
    $display("test immediate done");
  endtask : t_imm

  task automatic pcmi(input logic [15:0] w [8], input int n, input logic [31:0] rdv,
                      input logic [31:0] ptr, input logic [31:0] ea, input int cnt);
    ea_mode = 3'h7;
    ea_reg = 3'h3;
    mem_ind = 1'b1;
    ea_partner_model_i.load(w, n, 1'b1, 3, rdv);
    run();
    chk(ea_partner_model_i.addr_seen, ptr, "pointer");
    chk(ea_addr, ea, "pc indirect ea");
    chk(ext_count, cnt, "pc indirect count");
    chk({mem_prog, prog_space, write_fault}, 3'h7, "program read");
    mem_ind = 1'b0;
  endtask : pcmi

  task automatic t_pcmi();
    instr_addr = 32'h1000;
    {bd_size, od_size, index_val, index_scale} = {2'h1, 2'h2, 32'h00008004, 2'h2};
    pcmi('{16'hffff, 16'hfffe, 16'h0000, 16'h0010, 0, 0, 0, 0}, 4, 32'h40000000,
         32'hfffe1010, 32'h40000010, 4);
    {base_suppress, index_suppress, bd_size, od_size} = {1'b1, 1'b1, 2'h0, 2'h0};
    pcmi('{16'h0, 0, 0, 0, 0, 0, 0, 0}, 1, 32'h89abcdef, 32'h0, 32'h89abcdef, 1);
    {base_suppress, index_suppress, index_long, index_scale} = {1'b0, 1'b0, 1'b1, 2'h3};
    {instr_addr, index_val, bd_size, od_size} = {32'h2000, 32'h10, 2'h2, 2'h1};
    pcmi('{16'h0, 16'h0001, 16'h0000, 16'hfff0, 0, 0, 0, 0}, 4, 32'h100, 32'h00012082,
         32'h000000f0, 4);
    $display("test pc indirect done");
  endtask : t_pcmi

  initial begin
    {reset, start, mem_ind, base_suppress, index_suppress, index_long} = 6'h20;
    {ea_mode, ea_reg, bd_size, od_size, index_scale} = '0;
    {instr_addr, index_val} = '0;
    imm_size = IMM_WORD;
    need_cats = 6'h3f;
    write_dest = 1'b1;
    repeat (12) @(posedge mclk);
    #2 reset = 1'b0;
    chk({busy, done, mem_req, ext_ready, ea_addr}, 0, "reset state");
    t_classify();
    t_abs();
    t_imm();
    t_pcmi();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
